//--- hdl/thermo_consts.vh
`ifndef THERMO_CONSTS_VH
`define THERMO_CONSTS_VH

// rom-level command codes
`define CMD_READ_ID        8'h01
`define CMD_MATCH_ID       8'h02
`define CMD_SEARCH_ID      8'h03
`define CMD_SKIP_ID        8'h04
`define CMD_ALARM_SEARCH   8'h05

// memory and control command codes
`define CMD_CONVERT        8'h10
`define CMD_READ_SCRATCH   8'h11
`define CMD_WRITE_SCRATCH  8'h12
`define CMD_COPY_LIMITS    8'h13
`define CMD_RECALL_LIMITS  8'h14
`define CMD_READ_POWER     8'h15

// identifier and transfer sizes
`define ID_BITS            64
`define TEMP_BITS          9
`define SCRATCH_BITS       32

// nonvolatile limit values after reset
`define UPPER_LIMIT_RESET  8'h7d
`define LOWER_LIMIT_RESET  8'hc9

// conversion time and clock rate
`define CONV_TIME_MS       200
`define CLOCK_KHZ          250000
`define CONV_CYCLES        (`CONV_TIME_MS * `CLOCK_KHZ)

`endif

//--- hdl/lsb_first_rx.v
`timescale 1ns/1ns
module lsb_first_rx (
    input  wire       clock,
    input  wire       reset,
    input  wire       clear,
    input  wire       bit_valid,
    input  wire       bit_value,
    output reg  [7:0] data,
    output reg        done
);
    reg [2:0] count;

    always @(posedge clock or posedge reset) begin
        if (reset) begin
            data  <= 8'h00;
            count <= 3'h0;
            done  <= 1'b0;
        end else if (clear) begin
            count <= 3'h0;
            done  <= 1'b0;
        end else begin
            done <= bit_valid && (count == 3'h7);
            if (bit_valid) begin
                data  <= {bit_value, data[7:1]};
                count <= count + 3'h1;
            end
        end
    end
endmodule // lsb_first_rx

//--- hdl/conversion_unit.v
`timescale 1ns/1ns
`include "thermo_consts.vh"
module conversion_unit #(
    parameter CYCLES = `CONV_CYCLES,
    parameter CW     = 32
) (
    input  wire       clock,
    input  wire       reset,
    input  wire       start,
    input  wire [8:0] temp_sense,
    input  wire [7:0] upper_alarm_limit,
    input  wire [7:0] lower_alarm_limit,
    output reg        busy,
    output reg  [8:0] temperature,
    output reg        alarm
);
    localparam [CW-1:0] LOAD = CYCLES - 1;

    reg  [CW-1:0] count;
    // half-degree bit dropped so the whole-degree part lines up with the limit bytes
    wire signed [7:0] whole = temp_sense[8:1];

    always @(posedge clock or posedge reset) begin
        if (reset) begin
            busy        <= 1'b0;
            count       <= {CW{1'b0}};
            temperature <= 9'h000;
            alarm       <= 1'b0;
        end else if (busy) begin
            if (count == {CW{1'b0}}) begin
                busy        <= 1'b0;
                temperature <= temp_sense;
                alarm       <= (whole > $signed(upper_alarm_limit)) ||
                               (whole < $signed(lower_alarm_limit));
            end else begin
                count <= count - {{(CW-1){1'b0}}, 1'b1};
            end
        end else if (start) begin
            busy  <= 1'b1;
            count <= LOAD;
        end
    end
endmodule // conversion_unit

//--- hdl/thermo_cmd_layer.v
`timescale 1ns/1ns
`include "thermo_consts.vh"
module thermo_cmd_layer #(
    parameter [63:0] ROM_ID      = 64'h0000_0000_0000_0001, // arbitrary value
    parameter        CONV_CYCLES = `CONV_CYCLES,
    parameter        CONV_CW     = 32
) (
    input  wire       clock,
    input  wire       reset,
    input  wire       bus_reset,
    input  wire       slot_write,
    input  wire       slot_bit,
    input  wire       slot_read,
    input  wire [8:0] temp_sense,
    input  wire       vdd_present,
    output reg        reply_bit,
    output reg        selected,
    output wire       conv_busy,
    output wire       alarm_flag,
    output reg  [7:0] upper_alarm_limit,
    output reg  [7:0] lower_alarm_limit
);
    localparam [10:0] S_IDLE     = 11'h001;
    localparam [10:0] S_ROM_CMD  = 11'h002;
    localparam [10:0] S_ID_SEND  = 11'h004;
    localparam [10:0] S_ID_MATCH = 11'h008;
    localparam [10:0] S_ID_SRCH  = 11'h010;
    localparam [10:0] S_FUNC_CMD = 11'h020;
    localparam [10:0] S_SCR_SEND = 11'h040;
    localparam [10:0] S_SCR_RECV = 11'h080;
    localparam [10:0] S_POWER    = 11'h100;
    localparam [10:0] S_CONV     = 11'h200;
    localparam [10:0] S_DONE     = 11'h400;

    reg  [10:0] state;
    reg  [6:0]  bit_idx;
    reg  [1:0]  phase;
    reg  [63:0] tx_shift;
    reg         byte_sel;
    reg  [7:0]  scratch_upper;
    reg  [7:0]  scratch_lower;
    reg         conv_start;

    // id bit at a slot index; six bits wrap, so the look-ahead past bit 63 stays in range
    function id_at;
        input [5:0] idx;
        begin
            id_at = ROM_ID[idx];
        end
    endfunction

    // one lsb-first step; the vacated top fills with ones, the released-line level
    function [63:0] shift_out;
        input [63:0] word;
        begin
            shift_out = {1'b1, word[63:1]};
        end
    endfunction

    wire [7:0]  rx_data;
    wire        rx_done;
    wire [8:0]  temperature;
    wire        id_bit = id_at(bit_idx[5:0]);
    wire        last_bit = (bit_idx == 7'h3f);
    wire        rx_feed = slot_write &&
                          (state == S_ROM_CMD || state == S_FUNC_CMD || state == S_SCR_RECV);

    // readback image: temperature low, sign-extended high, then the limit copies
    wire [31:0] scratch_image = {scratch_lower, scratch_upper,
                                 {7{temperature[8]}}, temperature};

    lsb_first_rx u_rx (
        .clock     (clock),
        .reset     (reset),
        .clear     (bus_reset),
        .bit_valid (rx_feed),
        .bit_value (slot_bit),
        .data      (rx_data),
        .done      (rx_done)
    );

    conversion_unit #(
        .CYCLES (CONV_CYCLES),
        .CW     (CONV_CW)
    ) u_conv (
        .clock             (clock),
        .reset             (reset),
        .start             (conv_start),
        .temp_sense        (temp_sense),
        .upper_alarm_limit (upper_alarm_limit),
        .lower_alarm_limit (lower_alarm_limit),
        .busy              (conv_busy),
        .temperature       (temperature),
        .alarm             (alarm_flag)
    );

    always @(posedge clock or posedge reset) begin
        if (reset) begin
            state             <= S_IDLE;
            bit_idx           <= 7'h00;
            phase             <= 2'h0;
            tx_shift          <= {64{1'b1}};
            reply_bit         <= 1'b1;
            selected          <= 1'b0;
            byte_sel          <= 1'b0;
            conv_start        <= 1'b0;
            scratch_upper     <= `UPPER_LIMIT_RESET;
            scratch_lower     <= `LOWER_LIMIT_RESET;
            upper_alarm_limit <= `UPPER_LIMIT_RESET;
            lower_alarm_limit <= `LOWER_LIMIT_RESET;
        end else begin
            conv_start <= 1'b0;
            if (bus_reset) begin
                // a bus reset aborts any sequence; a running conversion keeps going
                state     <= S_ROM_CMD;
                selected  <= 1'b0;
                reply_bit <= 1'b1;
                tx_shift  <= {64{1'b1}};
                bit_idx   <= 7'h00;
                phase     <= 2'h0;
                byte_sel  <= 1'b0;
            end else begin
                case (state)
                    S_IDLE: begin
                        reply_bit <= 1'b1;
                    end
                    S_ROM_CMD: begin
                        if (rx_done) begin
                            bit_idx <= 7'h00;
                            phase   <= 2'h0;
                            case (rx_data)
                                `CMD_READ_ID: begin
                                    state     <= S_ID_SEND;
                                    tx_shift  <= ROM_ID;
                                    reply_bit <= ROM_ID[0];
                                end
                                `CMD_MATCH_ID: begin
                                    state <= S_ID_MATCH;
                                end
                                `CMD_SEARCH_ID: begin
                                    state     <= S_ID_SRCH;
                                    reply_bit <= ROM_ID[0];
                                end
                                `CMD_SKIP_ID: begin
                                    state    <= S_FUNC_CMD;
                                    selected <= 1'b1;
                                end
                                `CMD_ALARM_SEARCH: begin
                                    if (alarm_flag) begin
                                        state     <= S_ID_SRCH;
                                        reply_bit <= ROM_ID[0];
                                    end else begin
                                        state <= S_DONE;
                                    end
                                end
                                default: begin
                                    state <= S_DONE;
                                end
                            endcase
                        end
                    end
                    S_ID_SEND: begin
                        if (slot_read) begin
                            tx_shift  <= shift_out(tx_shift);
                            reply_bit <= tx_shift[1];
                            bit_idx   <= bit_idx + 7'h01;
                            if (last_bit) begin
                                state     <= S_FUNC_CMD;
                                selected  <= 1'b1;
                                reply_bit <= 1'b1;
                            end
                        end
                    end
                    S_ID_MATCH: begin
                        if (slot_write) begin
                            if (slot_bit != id_bit) begin
                                state <= S_DONE;
                            end else if (last_bit) begin
                                state    <= S_FUNC_CMD;
                                selected <= 1'b1;
                            end
                            bit_idx <= bit_idx + 7'h01;
                        end
                    end
                    S_ID_SRCH: begin
                        // per bit: send id bit, send its complement, then take master's choice
                        case (phase)
                            2'h0: begin
                                if (slot_read) begin
                                    phase     <= 2'h1;
                                    reply_bit <= ~id_bit;
                                end
                            end
                            2'h1: begin
                                if (slot_read) begin
                                    phase     <= 2'h2;
                                    reply_bit <= 1'b1;
                                end
                            end
                            default: begin
                                if (slot_write) begin
                                    phase   <= 2'h0;
                                    bit_idx <= bit_idx + 7'h01;
                                    if (slot_bit != id_bit) begin
                                        state <= S_DONE;
                                    end else if (last_bit) begin
                                        state    <= S_FUNC_CMD;
                                        selected <= 1'b1;
                                    end else begin
                                        reply_bit <= id_at(bit_idx[5:0] + 6'h01);
                                    end
                                end
                            end
                        endcase
                    end
                    S_FUNC_CMD: begin
                        if (rx_done) begin
                            selected <= 1'b0;
                            case (rx_data)
                                `CMD_CONVERT: begin
                                    state      <= S_CONV;
                                    conv_start <= 1'b1;
                                    reply_bit  <= 1'b0;
                                end
                                `CMD_READ_SCRATCH: begin
                                    state     <= S_SCR_SEND;
                                    tx_shift  <= {32'hffff_ffff, scratch_image};
                                    reply_bit <= scratch_image[0];
                                end
                                `CMD_WRITE_SCRATCH: begin
                                    state    <= S_SCR_RECV;
                                    byte_sel <= 1'b0;
                                end
                                `CMD_COPY_LIMITS: begin
                                    upper_alarm_limit <= scratch_upper;
                                    lower_alarm_limit <= scratch_lower;
                                    state             <= S_DONE;
                                end
                                `CMD_RECALL_LIMITS: begin
                                    scratch_upper <= upper_alarm_limit;
                                    scratch_lower <= lower_alarm_limit;
                                    state         <= S_DONE;
                                end
                                `CMD_READ_POWER: begin
                                    state     <= S_POWER;
                                    reply_bit <= vdd_present;
                                end
                                default: begin
                                    state <= S_DONE;
                                end
                            endcase
                        end
                    end
                    S_SCR_SEND: begin
                        if (slot_read) begin
                            tx_shift  <= shift_out(tx_shift);
                            reply_bit <= tx_shift[1];
                        end
                    end
                    S_SCR_RECV: begin
                        if (rx_done) begin
                            byte_sel <= 1'b1;
                            if (byte_sel) begin
                                scratch_lower <= rx_data;
                                state         <= S_DONE;
                            end else begin
                                scratch_upper <= rx_data;
                            end
                        end
                    end
                    S_POWER: begin
                        reply_bit <= vdd_present;
                    end
                    S_CONV: begin
                        // read slots show 0 while busy, 1 once the result is in place;
                        // the start pulse counts as busy, else a stray 1 shows before busy rises
                        reply_bit <= ~(conv_busy | conv_start);
                    end
                    S_DONE: begin
                        reply_bit <= 1'b1;
                    end
                    default: begin
                        state <= S_IDLE;
                    end
                endcase
            end
        end
    end
endmodule // thermo_cmd_layer

//--- test/thermo_cmd_properties.sv
`timescale 1ns/1ns
module thermo_cmd_checker #(
    parameter CONV_CYCLES = 200
) (
    input wire       clock,
    input wire       reset,
    input wire       bus_reset,
    input wire       slot_write,
    input wire       slot_bit,
    input wire       slot_read,
    input wire [8:0] temp_sense,
    input wire       vdd_present,
    input wire       reply_bit,
    input wire       selected,
    input wire       conv_busy,
    input wire       alarm_flag,
    input wire [7:0] upper_alarm_limit,
    input wire [7:0] lower_alarm_limit
);
    default clocking @(posedge clock);
    endclocking
    default disable iff (reset);
    wire        any_slot = slot_write | slot_read;
    wire [7:0]  whole    = temp_sense[8:1];
    reg  [31:0] busy_cnt;
    always @(posedge clock or posedge reset) begin
        if (reset)
            busy_cnt <= 32'h0;
        else if (conv_busy)
            busy_cnt <= busy_cnt + 32'h1;
        else
            busy_cnt <= 32'h0;
    end
    property p_reset_state;
        $fell(reset) |-> upper_alarm_limit == 8'h7d && lower_alarm_limit == 8'hc9
            && !selected && !conv_busy && !alarm_flag && reply_bit;
    endproperty
    a_reset_state: assert property (p_reset_state) else $error("bad state after reset");
    property p_sel_rise;
        $rose(selected) |-> $past(any_slot) || $past(any_slot, 2) || $past(any_slot, 3);
    endproperty
    a_sel_rise: assert property (p_sel_rise) else $error("selection without slot");
    property p_sel_fall;
        $fell(selected) |-> $past(slot_write, 2) || $past(bus_reset) || $past(bus_reset, 2);
    endproperty
    a_sel_fall: assert property (p_sel_fall) else $error("selection lost early");
    property p_limit_write;
        !$stable({upper_alarm_limit, lower_alarm_limit}) |-> !selected && $past(slot_write, 2);
    endproperty
    a_limit_write: assert property (p_limit_write) else $error("limits changed");
    property p_busy_cause;
        $rose(conv_busy) |-> $past(selected) || $past(selected, 2) || $past(selected, 3);
    endproperty
    a_busy_cause: assert property (p_busy_cause) else $error("unselected convert");
    property p_busy_len;
        $fell(conv_busy) |-> busy_cnt + 1 >= CONV_CYCLES && busy_cnt <= CONV_CYCLES + 1;
    endproperty
    a_busy_len: assert property (p_busy_len) else $error("conversion length wrong");
    property p_alarm_hold;
        !$stable(alarm_flag) |-> !conv_busy && ($past(conv_busy) || $past(conv_busy, 2));
    endproperty
    a_alarm_hold: assert property (p_alarm_hold) else $error("alarm moved");
    property p_alarm_value;
        $fell(conv_busy) |-> ##2 alarm_flag == ($signed(whole) > $signed(upper_alarm_limit)
            || $signed(whole) < $signed(lower_alarm_limit));
    endproperty
    a_alarm_value: assert property (p_alarm_value) else $error("alarm value wrong");
endmodule // thermo_cmd_checker

bind thermo_cmd_layer thermo_cmd_checker #(.CONV_CYCLES(CONV_CYCLES)) props (
    .clock(clock), .reset(reset), .bus_reset(bus_reset), .slot_write(slot_write),
    .slot_bit(slot_bit), .slot_read(slot_read), .temp_sense(temp_sense),
    .vdd_present(vdd_present), .reply_bit(reply_bit), .selected(selected),
    .conv_busy(conv_busy), .alarm_flag(alarm_flag),
    .upper_alarm_limit(upper_alarm_limit), .lower_alarm_limit(lower_alarm_limit));

//--- test/bus_master_model.sv
`timescale 1ns/1ns
`include "thermo_consts.vh"
module bus_master_model (
    input  wire clock,
    input  wire reply_bit,
    output reg  bus_reset,
    output reg  slot_write,
    output reg  slot_bit,
    output reg  slot_read
);
    reg parasite      = 1'b0;
    reg strong_pullup = 1'b0;
    initial begin
        bus_reset  = 1'b0;
        slot_write = 1'b0;
        slot_bit   = 1'b1;
        slot_read  = 1'b0;
    end
    task automatic pulse_reset();
        @(posedge clock);
        bus_reset     <= 1'b1;
        strong_pullup <= 1'b0;
        @(posedge clock);
        bus_reset <= 1'b0;
    endtask
    // released data shows the inverse so a stale bit cannot pass
    task automatic write_bit(input logic b);
        @(posedge clock);
        slot_write <= 1'b1;
        slot_bit   <= b;
        @(posedge clock);
        slot_write <= 1'b0;
        slot_bit   <= ~b;
    endtask
    task automatic write_byte(input logic [7:0] v);
        for (int i = 0; i < 8; i++)
            write_bit(v[i]);
        repeat (2) @(posedge clock);
        if (parasite && (v == `CMD_CONVERT || v == `CMD_COPY_LIMITS))
            strong_pullup <= 1'b1;
        #1;
    endtask
    task automatic read_bit(output logic b);
        @(posedge clock);
        slot_read <= 1'b1;
        #1 b = reply_bit;
        @(posedge clock);
        slot_read <= 1'b0;
    endtask
endmodule // bus_master_model

//--- test/single_wire_thermometer_cmd_layer_tb.sv
`timescale 1ns/1ns
`include "thermo_consts.vh"
`define CHECK(g, e) begin n_checks++; if ((g) !== (e)) begin miscompares++; \
    $display("BAD %0t got %h want %h", $time, g, e); end end
module single_wire_thermometer_cmd_layer_tb;
    localparam int          CONV = 200;
    localparam logic [63:0] ID   = 64'h5a3c_0f96_e1d2_b487; // arbitrary value
    reg          clock       = 1'b0;
    reg          reset       = 1'b1;
    reg  [8:0]   temp_sense  = 9'h000;
    reg          vdd_present = 1'b1;
    wire         bus_reset, slot_write, slot_bit, slot_read;
    wire         reply_bit, selected, conv_busy, alarm_flag;
    wire [7:0]   upper_alarm_limit, lower_alarm_limit;
    int          miscompares = 0;
    int          n_checks    = 0;
    int          tw, exp_temp, exp_su, exp_sl;
    int          up_off[3]   = '{-1, 0, 10};
    int          lo_off[3]   = '{-10, 0, 1};
    logic [63:0] got;
    logic        b, c;

    always #2 clock = ~clock;

    bus_master_model master (.clock(clock), .reply_bit(reply_bit), .bus_reset(bus_reset),
        .slot_write(slot_write), .slot_bit(slot_bit), .slot_read(slot_read));
    thermo_cmd_layer #(.ROM_ID(ID), .CONV_CYCLES(CONV)) DUT (.clock(clock), .reset(reset),
        .bus_reset(bus_reset), .slot_write(slot_write), .slot_bit(slot_bit),
        .slot_read(slot_read), .temp_sense(temp_sense), .vdd_present(vdd_present),
        .reply_bit(reply_bit), .selected(selected), .conv_busy(conv_busy),
        .alarm_flag(alarm_flag), .upper_alarm_limit(upper_alarm_limit),
        .lower_alarm_limit(lower_alarm_limit));

    task automatic stop_test();
        $display("checks %0d mismatches %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    task automatic sel_skip();
        master.pulse_reset();
        master.write_byte(`CMD_SKIP_ID);
    endtask
    task automatic read_n(input int n, output logic [63:0] v);
        v = 64'h0;
        for (int i = 0; i < n; i++)
            master.read_bit(v[i]);
        repeat (2) @(posedge clock);
        #1;
    endtask
    task automatic check_scratch();
        sel_skip();
        master.write_byte(`CMD_READ_SCRATCH);
        read_n(32, got);
        `CHECK(got[31:0], {exp_sl[7:0], exp_su[7:0], {7{exp_temp[8]}}, exp_temp[8:0]})
    endtask
    task automatic search(input logic [7:0] cmd, input logic live);
        master.pulse_reset();
        master.write_byte(cmd);
        for (int i = 0; i < 64; i++) begin
            master.read_bit(b);
            master.read_bit(c);
            `CHECK({b, c}, live ? {ID[i], ~ID[i]} : 2'b11)
            master.write_bit(ID[i]);
        end
        repeat (2) @(posedge clock);
        #1;
        `CHECK(selected, live)
    endtask

    initial begin
        #200000;
        miscompares++;
        $display("BAD %0t watchdog expired", $time);
        stop_test();
    end

    initial begin
        void'($urandom(32'h348f098b));
        repeat (12) @(posedge clock);
        reset <= 1'b0;
        @(posedge clock);
        #1;
        `CHECK({upper_alarm_limit, lower_alarm_limit}, 16'h7dc9)
        `CHECK({selected, conv_busy, alarm_flag}, 3'b000)
        $display("reset test done");
        master.write_byte(`CMD_CONVERT);
        master.pulse_reset();
        master.write_byte(`CMD_CONVERT);
        master.write_byte(`CMD_CONVERT);
        `CHECK({selected, conv_busy}, 2'b00)
        $display("no selection test done");
        for (int v = 0; v < 2; v++) begin
            @(posedge clock) vdd_present <= v[0];
            sel_skip();
            `CHECK(selected, 1'b1)
            master.write_byte(`CMD_READ_POWER);
            `CHECK(selected, 1'b0)
            repeat (2) begin
                master.read_bit(b);
                `CHECK(b, v[0])
            end
            master.parasite = ~b;
            sel_skip();
            master.write_byte(`CMD_COPY_LIMITS);
            `CHECK(master.strong_pullup, master.parasite)
        end
        $display("power test done");
        master.pulse_reset();
        master.write_byte(`CMD_READ_ID);
        read_n(64, got);
        `CHECK({got, selected}, {ID, 1'b1})
        for (int k = 0; k < 2; k++) begin
            master.pulse_reset();
            master.write_byte(`CMD_MATCH_ID);
            got = ID ^ (64'(k) << $urandom_range(63));
            for (int i = 0; i < 64; i++)
                master.write_bit(got[i]);
            repeat (2) @(posedge clock);
            #1;
            `CHECK(selected, k == 0)
        end
        search(`CMD_SEARCH_ID, 1'b1);
        $display("rom test done");
        for (int k = 0; k < 3; k++) begin
            tw = int'($urandom_range(160)) - 50;
            exp_su = (tw + up_off[k]) & 255;
            exp_sl = (tw + lo_off[k]) & 255;
            sel_skip();
            master.write_byte(`CMD_WRITE_SCRATCH);
            master.write_byte(exp_su[7:0]);
            master.write_byte(exp_sl[7:0]);
            sel_skip();
            master.write_byte(`CMD_COPY_LIMITS);
            `CHECK({upper_alarm_limit, lower_alarm_limit}, {exp_su[7:0], exp_sl[7:0]})
            exp_temp = (tw * 2 + int'($urandom_range(1))) & 511;
            @(posedge clock) temp_sense <= exp_temp[8:0];
            sel_skip();
            master.write_byte(`CMD_CONVERT);
            master.read_bit(b);
            `CHECK({conv_busy, b}, 2'b10)
            sel_skip();
            master.write_byte(`CMD_READ_POWER);
            master.read_bit(b);
            `CHECK({conv_busy, b}, 2'b11)
            for (int w = 0; w < 400 && conv_busy !== 1'b0; w++)
                @(posedge clock);
            repeat (3) @(posedge clock);
            #1;
            `CHECK({conv_busy, alarm_flag}, {1'b0, k != 1})
            check_scratch();
            search(`CMD_ALARM_SEARCH, k != 1);
        end
        sel_skip();
        master.write_byte(`CMD_WRITE_SCRATCH);
        master.write_byte(8'h5a);
        master.write_byte(8'ha5);
        sel_skip();
        master.write_byte(`CMD_RECALL_LIMITS);
        check_scratch();
        $display("conversion test done");
        stop_test();
    end
endmodule // single_wire_thermometer_cmd_layer_tb
